// File: emb_defines.svh
// Offsets, field positions, reset values and address ranges of the external bus interface
// ----------------------------------------------------------------------------
// Function
// - Clock output runs at half oscillator rate
// - Dynamic width on: width input picks 16/8
// - Dynamic width off: always 8-bit cycles
// - Fetch-kind high on external fetches, whole cycle
// - Fetch-kind low for data, external only
// - Select high maps 2000H-5FFFH on-chip
// - Address strobe: latch or address-valid form
// - Address-valid form returns high at end
// - Address strobe pulses only for external accesses
// - Read strobe only on external reads
// - Write pin: plain or low-byte, writes only
// - Plain every write; low-byte even bytes only
// - High pin: enable or odd-byte write strobe
// - High pin asserted only on external writes
// - Ready ignored outside external accesses
// - Code at 0000H-01FFH always fetched externally
// ----------------------------------------------------------------------------
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define EMB_CFG_OFS 4'h0
`define EMB_STAT_OFS 4'h4
`define EMB_CNT_OFS 4'h8
`define EMB_WAIT_OFS 4'hc

// ----------------------------------------------------------------------------
// Chip configuration register fields
// ----------------------------------------------------------------------------
`define EMB_CFG_DYNW_BIT 1
`define EMB_CFG_VALID_BIT 2
`define EMB_CFG_LOWWR_BIT 3
`define EMB_CFG_HIGHWR_BIT 4
`define EMB_CFG_MASK 8'h1e
`define EMB_CFG_RST 8'h00

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define EMB_STAT_BUSY_BIT 0
`define EMB_STAT_WIDE_BIT 1
`define EMB_STAT_EXT_BIT 2
`define EMB_STAT_WAIT_LSB 8

// ----------------------------------------------------------------------------
// Address ranges
// ----------------------------------------------------------------------------
`define EMB_ROM_LO 16'h2000
`define EMB_ROM_HI 16'h5fff
`define EMB_FORCE_LO 16'h0000
`define EMB_FORCE_HI 16'h01ff

`endif

// File: emb_pkg.sv
// Types and address decode shared by the external bus interface
`include "emb_defines.svh"

package emb_pkg;

	typedef enum logic [2:0] {
		EMB_IDLE = 3'b000,
		EMB_ADDR = 3'b001,
		EMB_DATA = 3'b010,
		EMB_END = 3'b011,
		EMB_INTL = 3'b100
	} emb_state_e;

	// Decides whether an access stays on chip
	function automatic logic emb_is_internal(input logic [15:0] addr, input logic fetch, input logic sel_high);
		logic low_ram;
		logic rom;
		low_ram = (addr <= `EMB_FORCE_HI);
		rom = (addr >= `EMB_ROM_LO) && (addr <= `EMB_ROM_HI);
		emb_is_internal = (low_ram && !fetch) || (rom && sel_high);
	endfunction : emb_is_internal

endpackage : emb_pkg

// File: emb_bus_iface.sv
// External memory bus interface: multiplexed bus sequencer with Avalon-MM register slave
`timescale 1ns/100ps
`include "emb_defines.svh"

module emb_bus_iface (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic core_req,
	input wire logic core_write,
	input wire logic core_fetch,
	input wire logic core_word,
	input wire logic [15:0] core_addr,
	input wire logic [15:0] core_wdata,
	output logic core_ack,
	output logic core_internal,
	output logic [15:0] core_rdata,
	input wire logic external_access_select,
	input wire logic bus_width_select,
	input wire logic ready,
	input wire logic [15:0] ad_in,
	output logic [15:0] ad_out,
	output logic ad_oe,
	output logic address_strobe,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic high_byte_n,
	output logic fetch_kind_flag,
	output logic half_rate_clock_out
);

	// ----------------------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------------------
	logic rst_meta_n;
	logic rst_n;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ----------------------------------------------------------------------------
	// Clock output
	// ----------------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			half_rate_clock_out <= 1'b0;
		end else begin
			half_rate_clock_out <= !half_rate_clock_out;
		end
	end

	// ----------------------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------------------
	logic [7:0] chip_config_register;
	emb_pkg::emb_state_e state;
	logic [15:0] cur_addr;
	logic cyc_write;
	logic cyc_fetch;
	logic cyc_word;
	logic [15:0] cyc_wdata;
	logic cyc_dynw;
	logic cyc_valid;
	logic cyc_lowwr;
	logic second;
	logic wide;
	logic last_wide;
	logic last_ext;
	logic [7:0] wait_cnt;
	logic [7:0] last_wait;
	logic [15:0] ext_cycles;
	logic [15:0] total_waits;
	logic accept;
	logic acc_internal;
	logic next_wide;
	logic lo_byte;
	logic hi_byte;
	logic [7:0] wr_byte;
	logic [15:0] lane_data;
	logic [7:0] rd_byte;

	// ----------------------------------------------------------------------------
	// Request decode and lane steering
	// ----------------------------------------------------------------------------
	// A new request is taken only once the previous acknowledge has gone by
	assign accept = (state == emb_pkg::EMB_IDLE) && core_req && !core_ack;
	assign acc_internal = emb_pkg::emb_is_internal(core_addr, core_fetch, external_access_select);
	assign next_wide = cyc_dynw ? bus_width_select : 1'b0;
	assign lo_byte = !cur_addr[0];
	assign hi_byte = cur_addr[0] || (next_wide && cyc_word);
	assign wr_byte = second ? cyc_wdata[15:8] : cyc_wdata[7:0];
	// Byte writes on a wide bus are copied to both lanes so either lane holds the data
	assign lane_data = (next_wide && cyc_word) ? cyc_wdata : {wr_byte, wr_byte};
	assign rd_byte = (wide && cur_addr[0]) ? ad_in[15:8] : ad_in[7:0];

	// ----------------------------------------------------------------------------
	// Bus cycle sequencer
	// ----------------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= emb_pkg::EMB_IDLE;
			cur_addr <= 16'h0000;
			cyc_write <= 1'b0;
			cyc_fetch <= 1'b0;
			cyc_word <= 1'b0;
			cyc_wdata <= 16'h0000;
			cyc_dynw <= 1'b0;
			cyc_valid <= 1'b0;
			cyc_lowwr <= 1'b0;
			second <= 1'b0;
			wide <= 1'b0;
			wait_cnt <= 8'h00;
		end else begin
			unique case (state)
				emb_pkg::EMB_IDLE: begin
					if (accept) begin
						cur_addr <= core_addr;
						cyc_write <= core_write;
						cyc_fetch <= core_fetch && !core_write;
						// Misaligned words are carried as a single byte
						cyc_word <= core_word && !core_addr[0];
						cyc_wdata <= core_wdata;
						cyc_dynw <= chip_config_register[`EMB_CFG_DYNW_BIT];
						cyc_valid <= chip_config_register[`EMB_CFG_VALID_BIT];
						// Both high-pin forms fall on the same bytes, so that bit only reads back
						cyc_lowwr <= chip_config_register[`EMB_CFG_LOWWR_BIT];
						second <= 1'b0;
						state <= acc_internal ? emb_pkg::EMB_INTL : emb_pkg::EMB_ADDR;
					end
				end
				emb_pkg::EMB_INTL: begin
					state <= emb_pkg::EMB_IDLE;
				end
				emb_pkg::EMB_ADDR: begin
					wide <= next_wide;
					wait_cnt <= 8'h00;
					state <= emb_pkg::EMB_DATA;
				end
				emb_pkg::EMB_DATA: begin
					if (ready) begin
						state <= emb_pkg::EMB_END;
					end else if (wait_cnt != 8'hff) begin
						wait_cnt <= wait_cnt + 8'h01;
					end
				end
				emb_pkg::EMB_END: begin
					// A word on an 8-bit cycle takes a second cycle at the odd address
					if (cyc_word && !wide && !second) begin
						second <= 1'b1;
						cur_addr <= cur_addr | 16'h0001;
						state <= emb_pkg::EMB_ADDR;
					end else begin
						state <= emb_pkg::EMB_IDLE;
					end
				end
				default: begin
					state <= emb_pkg::EMB_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ad_out <= 16'h0000;
			ad_oe <= 1'b0;
			address_strobe <= 1'b0;
			read_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			high_byte_n <= 1'b1;
			fetch_kind_flag <= 1'b0;
		end else begin
			unique case (state)
				emb_pkg::EMB_IDLE: begin
					if (accept && !acc_internal) begin
						ad_out <= core_addr;
						ad_oe <= 1'b1;
						// Latch form pulses high, address-valid form goes low
						address_strobe <= !chip_config_register[`EMB_CFG_VALID_BIT];
						fetch_kind_flag <= core_fetch && !core_write;
					end else begin
						// Idle level follows the form currently configured
						address_strobe <= chip_config_register[`EMB_CFG_VALID_BIT];
						fetch_kind_flag <= 1'b0;
					end
				end
				emb_pkg::EMB_INTL: begin
					address_strobe <= cyc_valid;
					fetch_kind_flag <= 1'b0;
				end
				emb_pkg::EMB_ADDR: begin
					if (!cyc_valid) begin
						address_strobe <= 1'b0;
					end
					if (cyc_write) begin
						ad_out <= lane_data;
						ad_oe <= 1'b1;
						write_strobe_n <= !(!cyc_lowwr || lo_byte);
						high_byte_n <= !hi_byte;
					end else begin
						ad_oe <= 1'b0;
						read_strobe_n <= 1'b0;
					end
				end
				emb_pkg::EMB_DATA: begin
					if (ready) begin
						read_strobe_n <= 1'b1;
						write_strobe_n <= 1'b1;
						high_byte_n <= 1'b1;
						ad_oe <= 1'b0;
						if (cyc_valid) begin
							address_strobe <= 1'b1;
						end
					end
				end
				emb_pkg::EMB_END: begin
					if (cyc_word && !wide && !second) begin
						ad_out <= cur_addr | 16'h0001;
						ad_oe <= 1'b1;
						address_strobe <= !cyc_valid;
						fetch_kind_flag <= cyc_fetch;
					end else begin
						fetch_kind_flag <= 1'b0;
					end
				end
				default: begin
					ad_oe <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------------------
	// Core answer
	// ----------------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_ack <= 1'b0;
			core_internal <= 1'b0;
			core_rdata <= 16'h0000;
		end else begin
			core_ack <= 1'b0;
			if (state == emb_pkg::EMB_INTL) begin
				core_ack <= 1'b1;
				core_internal <= 1'b1;
			end else if (accept && !acc_internal) begin
				core_internal <= 1'b0;
			end
			if (state == emb_pkg::EMB_DATA && ready && !cyc_write) begin
				if (wide && cyc_word) begin
					core_rdata <= ad_in;
				end else if (second) begin
					core_rdata[15:8] <= rd_byte;
				end else begin
					core_rdata <= {8'h00, rd_byte};
				end
			end
			if (state == emb_pkg::EMB_END && !(cyc_word && !wide && !second)) begin
				core_ack <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------------------
	// Cycle statistics
	// ----------------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_wide <= 1'b0;
			last_ext <= 1'b0;
			last_wait <= 8'h00;
			ext_cycles <= 16'h0000;
			total_waits <= 16'h0000;
		end else begin
			if (state == emb_pkg::EMB_INTL) begin
				last_ext <= 1'b0;
			end
			if (state == emb_pkg::EMB_DATA && !ready) begin
				total_waits <= total_waits + 16'h0001;
			end
			if (state == emb_pkg::EMB_DATA && ready) begin
				last_ext <= 1'b1;
				last_wide <= wide;
				last_wait <= wait_cnt;
				ext_cycles <= ext_cycles + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------------------
	// Avalon-MM slave
	// ----------------------------------------------------------------------------
	logic avs_req;
	logic [31:0] next_readdata;

	assign avs_req = avs_read || avs_write;

	always_comb begin
		next_readdata = 32'h0000_0000;
		unique case (avs_address)
			`EMB_CFG_OFS: next_readdata = {24'h00_0000, chip_config_register};
			`EMB_STAT_OFS: begin
				next_readdata[`EMB_STAT_BUSY_BIT] = (state != emb_pkg::EMB_IDLE);
				next_readdata[`EMB_STAT_WIDE_BIT] = last_wide;
				next_readdata[`EMB_STAT_EXT_BIT] = last_ext;
				next_readdata[`EMB_STAT_WAIT_LSB +: 8] = last_wait;
			end
			`EMB_CNT_OFS: next_readdata = {16'h0000, ext_cycles};
			`EMB_WAIT_OFS: next_readdata = {16'h0000, total_waits};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	// One wait state per access; the request completes on the edge after it is seen
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !(avs_req && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= next_readdata;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chip_config_register <= `EMB_CFG_RST;
		end else if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == `EMB_CFG_OFS) begin
			// Changes take hold at the next accepted access, the idle strobe level at once; never mid-cycle
			chip_config_register <= avs_writedata[7:0] & `EMB_CFG_MASK;
		end
	end

endmodule : emb_bus_iface

// File: emb_bus_iface_assertions.sv
// Port checker for the external bus interface
`timescale 1ns/100ps
module emb_bus_iface_assertions (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [3:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic ready,
	input wire logic ad_oe,
	input wire logic address_strobe,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic high_byte_n,
	input wire logic fetch_kind_flag,
	input wire logic half_rate_clock_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic [1:0] up_cnt;
	logic valid_form;
	// Skips the synchroniser delay after reset release
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) up_cnt <= 2'h0;
		else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
	end
	// Shadow of the strobe form bit, tracked from register writes
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) valid_form <= 1'b0;
		else if (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0]) valid_form <= avs_writedata[2];
	end
	property p_half_clk;
		up_cnt == 2'h3 |=> half_rate_clock_out != $past(half_rate_clock_out);
	endproperty
	a_half_clk: assert property (p_half_clk) else $error("clock output stalled");
	property p_read_only;
		!read_strobe_n |-> write_strobe_n && high_byte_n && !ad_oe;
	endproperty
	a_read_only: assert property (p_read_only) else $error("read strobe overlaps a write");
	property p_write_only;
		!write_strobe_n |-> read_strobe_n && ad_oe;
	endproperty
	a_write_only: assert property (p_write_only) else $error("write strobe outside a write");
	property p_high_write;
		!high_byte_n |-> read_strobe_n && ad_oe;
	endproperty
	a_high_write: assert property (p_high_write) else $error("high pin outside a write");
	property p_fetch_read;
		fetch_kind_flag |-> write_strobe_n && high_byte_n;
	endproperty
	a_fetch_read: assert property (p_fetch_read) else $error("fetch flag during a write");
	property p_fetch_hold;
		!read_strobe_n && fetch_kind_flag |=> fetch_kind_flag;
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("fetch flag dropped early");
	property p_wait;
		!read_strobe_n && !ready |=> !read_strobe_n;
	endproperty
	a_wait: assert property (p_wait) else $error("read ended while not ready");
	property p_finish;
		!read_strobe_n && ready |=> read_strobe_n;
	endproperty
	a_finish: assert property (p_finish) else $error("read not ended after ready");
	property p_adv_end;
		valid_form && !read_strobe_n && ready |-> !address_strobe ##1 address_strobe;
	endproperty
	a_adv_end: assert property (p_adv_end) else $error("address valid not returned high");
endmodule : emb_bus_iface_assertions
bind emb_bus_iface emb_bus_iface_assertions chk (.*);

// File: emb_mem_model.sv
// External byte memory with programmable wait cycles
`timescale 1ns/100ps
module emb_mem_model (
	input wire logic core_clk,
	input wire logic valid_form,
	input wire logic [3:0] stall,
	input wire logic [15:0] ad_out,
	input wire logic ad_oe,
	input wire logic address_strobe,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic high_byte_n,
	output logic [15:0] ad_in,
	output logic ready
);
	logic [7:0] mem [0:65535];
	logic [15:0] addr;
	logic [15:0] last;
	logic [3:0] cnt;
	logic act;
	assign act = !read_strobe_n || !write_strobe_n || !high_byte_n;
	// Held low when idle, so a design that listens outside a cycle hangs
	assign ready = act && cnt >= stall;
	// Released bus shows inverted data rather than a stale copy
	assign ad_in = read_strobe_n ? ~last : {mem[addr | 16'h1], mem[addr]};
	initial begin
		last = 16'h0;
		for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
	end
	always @(posedge core_clk) begin
		if ((address_strobe ^ valid_form) && ad_oe && !act) addr <= ad_out;
		cnt <= act ? cnt + 4'h1 : 4'h0;
		if (!read_strobe_n) last <= ad_in;
		// Even bank answers only the write pin, odd bank only the high pin
		if (addr[0] ? !high_byte_n : !write_strobe_n) mem[addr] <= ad_out[7:0];
	end
endmodule : emb_mem_model

// File: emb_bus_iface_tb.sv
// Self-checking bench for the external bus interface
`timescale 1ns/100ps
module emb_bus_iface_tb;
	logic core_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, core_req = 1'b0;
	logic core_write = 1'b0, core_fetch = 1'b0, core_word = 1'b0, valid_form = 1'b0;
	logic external_access_select = 1'b0, bus_width_select = 1'b0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf, stall = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [15:0] core_addr = 16'h0, core_wdata = 16'h0, core_rdata, ad_in, ad_out;
	logic avs_waitrequest, core_ack, core_internal, ready, ad_oe, address_strobe;
	logic read_strobe_n, write_strobe_n, high_byte_n, fetch_kind_flag, half_rate_clock_out;
	int failures = 0, total_checks = 0;
	emb_bus_iface dut (.*);
	emb_mem_model mem (.*);
	initial forever #5 core_clk = ~core_clk;
	function automatic logic [7:0] pat(input logic [15:0] a);
		pat = a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction : pat
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		n = 0;
		do @(posedge core_clk) n++; while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			failures++;
			finish_test();
		end
		@(posedge core_clk);
	endtask : av
	// Core access; op is {write, fetch, word}
	task automatic run(input logic [7:0] cfg, input logic sel, input logic w16, input logic [2:0] op,
			input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp, input logic iexp);
		int n;
		av(1'b1, 4'h0, {24'h0, cfg}, q);
		external_access_select <= sel;
		bus_width_select <= w16;
		valid_form <= cfg[2];
		{core_write, core_fetch, core_word} <= op;
		core_addr <= a;
		core_wdata <= d;
		core_req <= 1'b1;
		n = 0;
		do @(posedge core_clk) n++; while (core_ack !== 1'b1 && n < 100);
		core_req <= 1'b0;
		if (core_ack !== 1'b1) begin
			failures++;
			finish_test();
		end
		if (!op[2] && !iexp) check({16'h0, core_rdata}, {16'h0, exp});
		check({31'h0, core_internal}, {31'h0, iexp});
		@(posedge core_clk);
	endtask : run
	initial begin
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		av(1'b1, 4'h0, 32'hff, q);
		av(1'b0, 4'h0, 32'h0, q);
		check(q, 32'h1e);
		av(1'b0, 4'h2, 32'h0, q);
		check(q, 32'h0);
		$display("test registers done");
		run(8'h00, 1'b0, 1'b0, 3'b000, 16'h0100, 16'h0, 16'h0, 1'b1);
		run(8'h00, 1'b0, 1'b0, 3'b010, 16'h01fe, 16'h0, {8'h0, pat(16'h01fe)}, 1'b0);
		run(8'h00, 1'b1, 1'b0, 3'b000, 16'h5fff, 16'h0, 16'h0, 1'b1);
		run(8'h00, 1'b0, 1'b0, 3'b000, 16'h2000, 16'h0, {8'h0, pat(16'h2000)}, 1'b0);
		$display("test address map done");
		stall <= 4'h3;
		run(8'h00, 1'b0, 1'b0, 3'b100, 16'h8001, 16'h00a5, 16'h0, 1'b0);
		run(8'h18, 1'b0, 1'b0, 3'b100, 16'h8002, 16'h003c, 16'h0, 1'b0);
		run(8'h18, 1'b0, 1'b0, 3'b100, 16'h8003, 16'h00c3, 16'h0, 1'b0);
		run(8'h00, 1'b0, 1'b0, 3'b000, 16'h8001, 16'h0, 16'h00a5, 1'b0);
		run(8'h00, 1'b0, 1'b0, 3'b001, 16'h8002, 16'h0, 16'hc33c, 1'b0);
		av(1'b0, 4'h4, 32'h0, q);
		check(q, 32'h0000_0304);
		av(1'b0, 4'hc, 32'h0, q);
		check(q, 32'h0000_0012);
		$display("test writes and waits done");
		stall <= 4'h0;
		for (int i = 0; i < 3; i++) begin
			run({6'h0, i != 0, 1'b0}, 1'b0, i != 2, 3'b001, 16'h8004, 16'h0, {pat(16'h8005), pat(16'h8004)}, 1'b0);
			av(1'b0, 4'h4, 32'h0, q);
			check(q & 32'h2, {30'h0, i == 1, 1'b0});
		end
		$display("test bus width done");
		stall <= 4'h2;
		run(8'h04, 1'b0, 1'b0, 3'b010, 16'h9000, 16'h0, {8'h0, pat(16'h9000)}, 1'b0);
		$display("test address valid form done");
		finish_test();
	end
endmodule : emb_bus_iface_tb
